/* File: hdl/sysref_sync_ctrl_map.svh */
/*
  Register offsets, field positions, reset values and delay figures for the
  reference and sync control register bank.
  Assumes a 24-bit configuration frame: read flag, page bits, 12-bit offset, data.
*/
`ifndef SYSREF_SYNC_CTRL_MAP_SVH
`define SYSREF_SYNC_CTRL_MAP_SVH

// Register offsets
`define OFS_REF_DELAY_CTRL 12'h003C
`define OFS_SERIAL_OUTPUT_SWING 12'h003D
`define OFS_REFERENCE_SOURCE_CTRL 12'h0057
`define OFS_SYNC_POLARITY_CTRL 12'h0058
`define OFS_REFERENCE_DELAY_LOW 12'h005A

// Reset values, all registers
`define REG_RESET_VALUE 8'h00

// Field positions
`define FLD_DELAY_ENABLE 6
`define FLD_DELAY_HIGH_MSB 1
`define FLD_DELAY_HIGH_LSB 0
`define FLD_DELAY_LOW_MSB 7
`define FLD_DELAY_LOW_LSB 5
`define FLD_SWING_MSB 2
`define FLD_SWING_LSB 0
`define FLD_SOURCE_SELECT 3
`define FLD_LEVEL_BIT 4
`define FLD_SYNC_INVERT 5

// Configuration frame layout
`define FRAME_BITS 24
`define FRAME_HEADER_LAST 5'd15
`define FRAME_LAST 5'd23
`define FRAME_READ_BIT 15

// Reference delay figures: step sizes in picoseconds, then the first code
`define REF_DELAY_FIRST_STEP_PS 10'd175
`define REF_DELAY_STEP_PS 10'd25
`define REF_DELAY_FIRST_CODE 5'd8

// Lane swing amplitudes in millivolts, per code
`define SWING_MV_0 10'd860
`define SWING_MV_1 10'd810
`define SWING_MV_2 10'd770
`define SWING_MV_3 10'd745
`define SWING_MV_4 10'd960
`define SWING_MV_5 10'd930
`define SWING_MV_6 10'd905
`define SWING_MV_7 10'd880

`endif

/* File: hdl/sysref_sync_ctrl_pkg.sv */
/*
  Types shared by the reference and sync control register bank.
  Assumes the constants header is included by each design file.
*/
package sysref_sync_ctrl_pkg;
  // Phase of a configuration frame
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HEADER,
    PH_DATA
  } frame_phase_t;
endpackage

/* File: hdl/ref_delay_path.sv */
/*
  Reference delay path: decodes the five-bit delay code into a nominal delay
  word for the analog delay cell and registers the selected reference.
  Assumes the reference level is already synchronised to i_clk.
*/
`timescale 1ns/1ns
`include "sysref_sync_ctrl_map.svh"

module ref_delay_path (
  input wire logic i_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_ref_level, // Selected reference level
  input wire logic i_delay_enable, // Delay enable bit
  input wire logic [4:0] i_delay_code, // Five-bit delay code
  output logic o_ref_out, // Reference toward capture
  output logic o_delay_on, // Delay cell engaged
  output logic [9:0] o_delay_ps // Nominal delay, ps
);

  logic ref_ff;
  logic nxt_ref;
  logic on_ff;
  logic nxt_on;
  logic [9:0] ps_ff;
  logic [9:0] nxt_ps;
  logic [4:0] steps;

  // Decode: first code is the base step, each code below adds one step
  always_comb begin
    steps = 5'd0;
    nxt_on = i_delay_enable;
    nxt_ps = 10'd0;
    nxt_ref = i_ref_level;
    if (i_delay_enable) begin
      // Codes above the first step are undefined; they get the base step only
      if (i_delay_code <= `REF_DELAY_FIRST_CODE) begin
        steps = `REF_DELAY_FIRST_CODE - i_delay_code;
      end
      nxt_ps = `REF_DELAY_FIRST_STEP_PS + 10'(steps * `REF_DELAY_STEP_PS);
    end
  end

  // Registered so the delay word and reference change together
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ref_ff <= 1'b0;
      on_ff <= 1'b0;
      ps_ff <= 10'd0;
    end else begin
      ref_ff <= nxt_ref;
      on_ff <= nxt_on;
      ps_ff <= nxt_ps;
    end
  end

  assign o_ref_out = ref_ff;
  assign o_delay_on = on_ff;
  assign o_delay_ps = ps_ff;

endmodule // ref_delay_path

/* File: hdl/sysref_sync_ctrl_regs.sv */
/*
  Reference and sync control register bank with its serial configuration
  port, reference source mux, sync polarity and lane swing selection.
  Assumes serial pins, reference pin and sync pin are asynchronous to i_clk
  and that the serial clock runs well below a quarter of i_clk.
*/
`timescale 1ns/1ns
`include "sysref_sync_ctrl_map.svh"

module sysref_sync_ctrl_regs (
  input wire logic i_clk, // System clock, 125 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_sen_n, // Serial enable, active low
  input wire logic i_sclk, // Serial clock
  input wire logic i_sdi, // Serial data in
  input wire logic i_ref_pin, // Reference from device pins
  input wire logic i_sync_req_pin, // Sync request from pins
  output logic o_sdout, // Serial data out
  output logic o_sdout_oe, // Serial out enable
  output logic o_ref_capture, // Delayed reference to capture
  output logic o_ref_delay_on, // Delay cell engaged
  output logic [9:0] o_ref_delay_ps, // Nominal delay, ps
  output logic o_sync_req, // Sync request after polarity
  output logic [2:0] o_lane_swing_code, // Swing code, all lanes
  output logic [9:0] o_lane_swing_mv // Nominal swing, mV
);

  // Pin synchronisers: sen, sclk, sdi, reference, sync
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  logic [4:0] nxt_pin_meta;
  logic [4:0] nxt_pin_sync;
  logic sclk_prev_ff;
  logic nxt_sclk_prev;
  logic sen_n_s;
  logic sclk_s;
  logic sdi_s;
  logic ref_pin_s;
  logic sync_pin_s;
  logic sclk_rise;
  logic sclk_fall;

  // Registers
  logic [7:0] delay_ctrl_ff;
  logic [7:0] swing_ff;
  logic [7:0] source_ff;
  logic [7:0] polarity_ff;
  logic [7:0] delay_low_ff;
  logic [7:0] nxt_delay_ctrl;
  logic [7:0] nxt_swing;
  logic [7:0] nxt_source;
  logic [7:0] nxt_polarity;
  logic [7:0] nxt_delay_low;

  // Frame engine
  sysref_sync_ctrl_pkg::frame_phase_t phase_ff;
  sysref_sync_ctrl_pkg::frame_phase_t nxt_phase;
  logic [4:0] bit_cnt_ff;
  logic [4:0] nxt_bit_cnt;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic [15:0] shifted;
  logic [11:0] addr_ff;
  logic [11:0] nxt_addr;
  logic read_ff;
  logic nxt_read;
  logic [7:0] tx_ff;
  logic [7:0] nxt_tx;
  logic sdout_ff;
  logic nxt_sdout;
  logic oe_ff;
  logic nxt_oe;
  logic [7:0] rd_data;

  // Outputs
  logic sync_ff;
  logic nxt_sync;
  logic [2:0] swing_code_ff;
  logic [9:0] swing_mv_ff;
  logic [2:0] nxt_swing_code;
  logic [9:0] nxt_swing_mv;
  logic ref_selected;
  logic [4:0] delay_code;

  assign sen_n_s = pin_sync_ff[0];
  assign sclk_s = pin_sync_ff[1];
  assign sdi_s = pin_sync_ff[2];
  assign ref_pin_s = pin_sync_ff[3];
  assign sync_pin_s = pin_sync_ff[4];
  assign sclk_rise = sclk_s & ~sclk_prev_ff;
  assign sclk_fall = ~sclk_s & sclk_prev_ff;

  // Two stages per pin; only the second stage is looked at
  always_comb begin
    nxt_pin_meta = {i_sync_req_pin, i_ref_pin, i_sdi, i_sclk, i_sen_n};
    nxt_pin_sync = pin_meta_ff;
    nxt_sclk_prev = sclk_s;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_meta_ff <= 5'h01;
      pin_sync_ff <= 5'h01;
      sclk_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= nxt_pin_meta;
      pin_sync_ff <= nxt_pin_sync;
      sclk_prev_ff <= nxt_sclk_prev;
    end
  end

  // Read mux; reserved bits and unmapped offsets read as zero
  always_comb begin
    case (shifted[11:0])
      `OFS_REF_DELAY_CTRL: rd_data = delay_ctrl_ff;
      `OFS_SERIAL_OUTPUT_SWING: rd_data = swing_ff;
      `OFS_REFERENCE_SOURCE_CTRL: rd_data = source_ff;
      `OFS_SYNC_POLARITY_CTRL: rd_data = polarity_ff;
      `OFS_REFERENCE_DELAY_LOW: rd_data = delay_low_ff;
      default: rd_data = 8'h00;
    endcase
  end

  // Frame engine: sample on rising serial edge, drive read data on falling
  always_comb begin
    shifted = {shift_ff[14:0], sdi_s};
    nxt_phase = phase_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_read = read_ff;
    nxt_tx = tx_ff;
    nxt_sdout = sdout_ff;
    nxt_oe = oe_ff;
    nxt_delay_ctrl = delay_ctrl_ff;
    nxt_swing = swing_ff;
    nxt_source = source_ff;
    nxt_polarity = polarity_ff;
    nxt_delay_low = delay_low_ff;
    if (sen_n_s) begin
      // Deselect aborts any partial frame
      nxt_phase = sysref_sync_ctrl_pkg::PH_IDLE;
      nxt_bit_cnt = 5'd0;
      nxt_oe = 1'b0;
      nxt_sdout = 1'b0;
    end else begin
      case (phase_ff)
        sysref_sync_ctrl_pkg::PH_IDLE: begin
          nxt_phase = sysref_sync_ctrl_pkg::PH_HEADER;
        end
        sysref_sync_ctrl_pkg::PH_HEADER: begin
          if (sclk_rise) begin
            nxt_shift = shifted;
            nxt_bit_cnt = bit_cnt_ff + 5'd1;
            if (bit_cnt_ff == `FRAME_HEADER_LAST) begin
              nxt_phase = sysref_sync_ctrl_pkg::PH_DATA;
              nxt_read = shifted[`FRAME_READ_BIT];
              nxt_addr = shifted[11:0];
              nxt_tx = rd_data;
            end
          end
        end
        sysref_sync_ctrl_pkg::PH_DATA: begin
          if (sclk_fall && read_ff) begin
            nxt_oe = 1'b1;
            nxt_sdout = tx_ff[7];
            nxt_tx = {tx_ff[6:0], 1'b0};
          end
          if (sclk_rise && bit_cnt_ff <= `FRAME_LAST) begin
            nxt_shift = shifted;
            nxt_bit_cnt = bit_cnt_ff + 5'd1;
            if (bit_cnt_ff == `FRAME_LAST && !read_ff) begin
              // Writes keep only the defined bits
              case (addr_ff)
                `OFS_REF_DELAY_CTRL: begin
                  nxt_delay_ctrl = shifted[7:0] & 8'h43;
                end
                `OFS_SERIAL_OUTPUT_SWING: begin
                  nxt_swing = shifted[7:0] & 8'h07;
                end
                `OFS_REFERENCE_SOURCE_CTRL: begin
                  nxt_source = shifted[7:0] & 8'h18;
                end
                `OFS_SYNC_POLARITY_CTRL: begin
                  nxt_polarity = shifted[7:0] & 8'h20;
                end
                `OFS_REFERENCE_DELAY_LOW: begin
                  nxt_delay_low = shifted[7:0] & 8'hE0;
                end
                default: begin
                  nxt_shift = shifted;
                end
              endcase
            end
          end
        end
        default: begin
          nxt_phase = sysref_sync_ctrl_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_ff <= sysref_sync_ctrl_pkg::PH_IDLE;
      bit_cnt_ff <= 5'd0;
      shift_ff <= 16'h0000;
      addr_ff <= 12'h000;
      read_ff <= 1'b0;
      tx_ff <= 8'h00;
      sdout_ff <= 1'b0;
      oe_ff <= 1'b0;
      delay_ctrl_ff <= `REG_RESET_VALUE;
      swing_ff <= `REG_RESET_VALUE;
      source_ff <= `REG_RESET_VALUE;
      polarity_ff <= `REG_RESET_VALUE;
      delay_low_ff <= `REG_RESET_VALUE;
    end else begin
      phase_ff <= nxt_phase;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      read_ff <= nxt_read;
      tx_ff <= nxt_tx;
      sdout_ff <= nxt_sdout;
      oe_ff <= nxt_oe;
      delay_ctrl_ff <= nxt_delay_ctrl;
      swing_ff <= nxt_swing;
      source_ff <= nxt_source;
      polarity_ff <= nxt_polarity;
      delay_low_ff <= nxt_delay_low;
    end
  end

  // Reference source mux; level bit is honoured only with register source
  // selected, so the host must set the source first to avoid a pin glitch
  assign ref_selected = source_ff[`FLD_SOURCE_SELECT] ?
    source_ff[`FLD_LEVEL_BIT] : ref_pin_s;
  assign delay_code = {delay_ctrl_ff[`FLD_DELAY_HIGH_MSB:`FLD_DELAY_HIGH_LSB],
    delay_low_ff[`FLD_DELAY_LOW_MSB:`FLD_DELAY_LOW_LSB]};

  ref_delay_path u_ref_delay (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ref_level(ref_selected),
    .i_delay_enable(delay_ctrl_ff[`FLD_DELAY_ENABLE]),
    .i_delay_code(delay_code),
    .o_ref_out(o_ref_capture),
    .o_delay_on(o_ref_delay_on),
    .o_delay_ps(o_ref_delay_ps)
  );

  // Sync polarity and lane swing decode
  always_comb begin
    nxt_sync = sync_pin_s ^ polarity_ff[`FLD_SYNC_INVERT];
    nxt_swing_code = swing_ff[`FLD_SWING_MSB:`FLD_SWING_LSB];
    case (nxt_swing_code)
      3'd0: nxt_swing_mv = `SWING_MV_0;
      3'd1: nxt_swing_mv = `SWING_MV_1;
      3'd2: nxt_swing_mv = `SWING_MV_2;
      3'd3: nxt_swing_mv = `SWING_MV_3;
      3'd4: nxt_swing_mv = `SWING_MV_4;
      3'd5: nxt_swing_mv = `SWING_MV_5;
      3'd6: nxt_swing_mv = `SWING_MV_6;
      default: nxt_swing_mv = `SWING_MV_7;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_ff <= 1'b0;
      swing_code_ff <= 3'd0;
      swing_mv_ff <= `SWING_MV_0;
    end else begin
      sync_ff <= nxt_sync;
      swing_code_ff <= nxt_swing_code;
      swing_mv_ff <= nxt_swing_mv;
    end
  end

  assign o_sdout = sdout_ff;
  assign o_sdout_oe = oe_ff;
  assign o_sync_req = sync_ff;
  assign o_lane_swing_code = swing_code_ff;
  assign o_lane_swing_mv = swing_mv_ff;

endmodule // sysref_sync_ctrl_regs

/* File: verif/sysref_sync_ctrl_regs_assertions.sv */
/*
  Concurrent checks on the reference and sync control bank ports.
  Assumes the host holds serial enable low 8 clocks past its last edge.
*/
`timescale 1ns/1ns
`include "sysref_sync_ctrl_map.svh"
module sysref_sync_ctrl_regs_assertions (
  input wire logic i_clk, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic i_sen_n, // Serial enable
  input wire logic i_sclk, // Serial clock
  input wire logic i_sdi, // Serial data
  input wire logic i_ref_pin, // Reference pin
  input wire logic i_sync_req_pin, // Sync pin
  input wire logic o_sdout, // Read data
  input wire logic o_sdout_oe, // Read enable
  input wire logic o_ref_capture, // Reference out
  input wire logic o_ref_delay_on, // Delay engaged
  input wire logic [9:0] o_ref_delay_ps, // Delay ps
  input wire logic o_sync_req, // Sync out
  input wire logic [2:0] o_lane_swing_code, // Swing code
  input wire logic [9:0] o_lane_swing_mv // Swing mV
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  localparam logic [9:0] MV_TAB [8] = '{`SWING_MV_0, `SWING_MV_1, `SWING_MV_2,
    `SWING_MV_3, `SWING_MV_4, `SWING_MV_5, `SWING_MV_6, `SWING_MV_7};

  // Amplitude always tracks the code, one table for all lanes
  chk_swing_table: assert property (o_lane_swing_mv == MV_TAB[o_lane_swing_code])
    else $error("swing amplitude does not match code");
  chk_delay_gate: assert property (o_ref_delay_on == (o_ref_delay_ps != 10'h000))
    else $error("delay present without enable");
  chk_delay_grid: assert property (o_ref_delay_on |->
    ((o_ref_delay_ps - `REF_DELAY_FIRST_STEP_PS) % `REF_DELAY_STEP_PS) == 10'h000)
    else $error("delay off the step grid");
  chk_delay_range: assert property (o_ref_delay_on |->
    o_ref_delay_ps inside {[`REF_DELAY_FIRST_STEP_PS:10'h177]})
    else $error("delay outside code range");
  // Settings move only while a frame is open
  chk_delay_quiet: assert property ($changed(o_ref_delay_ps) |-> !$past(i_sen_n, 2))
    else $error("delay changed with no frame");
  chk_swing_quiet: assert property ($changed(o_lane_swing_code) |-> !$past(i_sen_n, 2))
    else $error("swing changed with no frame");
  // Outside frames an output edge needs a pin edge; window allows sync slack
  chk_ref_follow: assert property ($changed(o_ref_capture) && i_sen_n && $past(i_sen_n, 8)
    |-> $past(i_ref_pin, 2) != $past(i_ref_pin, 5))
    else $error("reference moved without pin edge");
  chk_sync_follow: assert property ($changed(o_sync_req) && i_sen_n && $past(i_sen_n, 8)
    |-> $past(i_sync_req_pin, 2) != $past(i_sync_req_pin, 5))
    else $error("sync moved without pin edge");
endmodule // sysref_sync_ctrl_regs_assertions

bind sysref_sync_ctrl_regs sysref_sync_ctrl_regs_assertions sysref_sync_ctrl_regs_assertions_i (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_sen_n(i_sen_n), .i_sclk(i_sclk), .i_sdi(i_sdi),
  .i_ref_pin(i_ref_pin), .i_sync_req_pin(i_sync_req_pin), .o_sdout(o_sdout),
  .o_sdout_oe(o_sdout_oe), .o_ref_capture(o_ref_capture), .o_ref_delay_on(o_ref_delay_on),
  .o_ref_delay_ps(o_ref_delay_ps), .o_sync_req(o_sync_req),
  .o_lane_swing_code(o_lane_swing_code), .o_lane_swing_mv(o_lane_swing_mv));

/* File: verif/spi_host.sv */
/*
  Host side of the serial configuration port: one 24-bit frame per call.
  Assumes it is called on a falling clock edge.
*/
`timescale 1ns/1ns
module spi_host (
  input wire logic i_clk, // Bench clock
  input wire logic i_sdout, // Device read data
  input wire logic i_sdout_oe, // Device read enable
  output logic o_sen_n, // Serial enable, active low
  output logic o_sclk, // Serial clock
  output logic o_sdi // Serial data
);
  logic oe_mid; // Read enable seen at the first data sample
  // Idle: not selected, clock parked low
  initial begin
    o_sen_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    oe_mid = 1'b0;
  end
  // Six cycles per phase so edges survive the device synchroniser
  task automatic xfer(input logic rd, input logic [11:0] ofs, input logic [7:0] wd,
                      output logic [7:0] rq);
    logic [23:0] frame;
    frame = {rd, 3'h0, ofs, wd};
    rq = 8'h00;
    o_sen_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_sdi = frame[i];
      repeat (6) @(negedge i_clk);
      if (i < 8) rq[i] = i_sdout;
      if (i == 7) oe_mid = i_sdout_oe;
      o_sclk = 1'b1;
      repeat (6) @(negedge i_clk);
    end
    repeat (8) @(negedge i_clk);
    o_sen_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = ~o_sdi; // Released line shows no stale level
    repeat (10) @(negedge i_clk);
  endtask
endmodule // spi_host

/* File: verif/sysref_sync_ctrl_regs_bench.sv */
/*
  Self-checking bench for the reference and sync control bank.
  Assumes the host model drives the serial pins; pins change on falling edges.
*/
`timescale 1ns/1ns
`include "sysref_sync_ctrl_map.svh"
module sysref_sync_ctrl_regs_bench;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ref_pin = 1'b0;
  logic i_sync_req_pin = 1'b0;
  logic sen_n, sclk, sdi, o_sdout, o_sdout_oe, o_ref_capture, o_ref_delay_on, o_sync_req;
  logic [9:0] o_ref_delay_ps, o_lane_swing_mv;
  logic [2:0] o_lane_swing_code;
  logic [7:0] rdata;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  spi_host spi_host_i (.i_clk(i_clk), .i_sdout(o_sdout), .i_sdout_oe(o_sdout_oe),
    .o_sen_n(sen_n), .o_sclk(sclk), .o_sdi(sdi));
  sysref_sync_ctrl_regs sysref_sync_ctrl_regs_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_sen_n(sen_n), .i_sclk(sclk), .i_sdi(sdi), .i_ref_pin(i_ref_pin),
    .i_sync_req_pin(i_sync_req_pin), .o_sdout(o_sdout), .o_sdout_oe(o_sdout_oe),
    .o_ref_capture(o_ref_capture), .o_ref_delay_on(o_ref_delay_on),
    .o_ref_delay_ps(o_ref_delay_ps), .o_sync_req(o_sync_req),
    .o_lane_swing_code(o_lane_swing_code), .o_lane_swing_mv(o_lane_swing_mv));

  // 125 MHz clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // Hang guard, about twice the expected run
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: saw %0d want %0d", $time, what, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wr(input logic [11:0] ofs, input logic [7:0] d);
    spi_host_i.xfer(1'b0, ofs, d, rdata);
    // Writes must never turn the read driver on
    check({9'h000, spi_host_i.oe_mid}, 10'h000, "oe wr");
  endtask
  task automatic rd_chk(input logic [11:0] ofs, input logic [7:0] exp, input string what);
    spi_host_i.xfer(1'b1, ofs, 8'h00, rdata);
    check({2'h0, rdata}, {2'h0, exp}, what);
    // Driver on during the data phase, off once deselected
    check({9'h000, spi_host_i.oe_mid}, 10'h001, "oe rd");
    check({9'h000, o_sdout_oe}, 10'h000, "oe off");
  endtask

  // Reset values of delay enable and swing amplitude outputs and all five registers
  task automatic t_reset();
    check({9'h000, o_ref_delay_on}, 10'h000, "delay on");
    check(o_lane_swing_mv, `SWING_MV_0, "swing mv");
    rd_chk(12'h03c, 8'h00, "rst 3c");
    rd_chk(12'h03d, 8'h00, "rst 3d");
    rd_chk(12'h057, 8'h00, "rst 57");
    rd_chk(12'h058, 8'h00, "rst 58");
    rd_chk(12'h05a, 8'h00, "rst 5a");
    $display("test reset done");
  endtask
  // Every swing code, reserved bits set; then an unmapped place
  task automatic t_swing();
    logic [9:0] mv [8] = '{`SWING_MV_0, `SWING_MV_1, `SWING_MV_2, `SWING_MV_3,
      `SWING_MV_4, `SWING_MV_5, `SWING_MV_6, `SWING_MV_7};
    for (int c = 0; c < 8; c++) begin
      wr(12'h03d, 8'hf8 | 8'(c));
      rd_chk(12'h03d, 8'(c), "swing rd");
      check({7'h00, o_lane_swing_code}, 10'(c), "code");
      check(o_lane_swing_mv, mv[c], "mv");
    end
    wr(12'h03e, 8'hff);
    rd_chk(12'h03e, 8'h00, "unmapped");
    $display("test swing done");
  endtask
  // Gating, first step from the high bits, then codes 7 down to 3
  task automatic t_delay();
    wr(12'h05a, 8'h00);
    wr(12'h03c, 8'h01);
    check(o_ref_delay_ps, 10'h000, "gated");
    wr(12'h03c, 8'h41);
    check(o_ref_delay_ps, `REF_DELAY_FIRST_STEP_PS, "first");
    check({9'h000, o_ref_delay_on}, 10'h001, "on");
    // Codes above the first step fall back to the base step
    wr(12'h05a, 8'hff);
    check(o_ref_delay_ps, `REF_DELAY_FIRST_STEP_PS, "above");
    rd_chk(12'h05a, 8'he0, "low mask");
    wr(12'h03c, 8'hfc);
    for (int c = 7; c >= 3; c--) begin
      wr(12'h05a, 8'(c << 5));
      check(o_ref_delay_ps, `REF_DELAY_FIRST_STEP_PS +
        (10'(`REF_DELAY_FIRST_CODE) - 10'(c)) * `REF_DELAY_STEP_PS, "step");
    end
    rd_chk(12'h05a, 8'h60, "low rd");
    rd_chk(12'h03c, 8'h40, "en rd");
    wr(12'h03c, 8'h00);
    check(o_ref_delay_ps, 10'h000, "off");
    $display("test delay done");
  endtask
  // Pin path, then register source with both levels
  task automatic t_ref();
    i_ref_pin = 1'b1;
    idle(6);
    check({9'h000, o_ref_capture}, 10'h001, "pin");
    wr(12'h057, 8'h08); // Source chosen before level
    check({9'h000, o_ref_capture}, 10'h000, "lvl low");
    wr(12'h057, 8'hff); // Reserved bits must drop
    i_ref_pin = 1'b0;
    idle(6);
    check({9'h000, o_ref_capture}, 10'h001, "lvl high");
    rd_chk(12'h057, 8'h18, "src rd");
    wr(12'h057, 8'h00);
    check({9'h000, o_ref_capture}, 10'h000, "back");
    $display("test ref done");
  endtask
  // Normal polarity with the pin high, inverted polarity against both pin levels
  task automatic t_sync();
    i_sync_req_pin = 1'b1;
    idle(6);
    check({9'h000, o_sync_req}, 10'h001, "norm");
    wr(12'h058, 8'hff); // Reserved bits must drop
    check({9'h000, o_sync_req}, 10'h000, "inv hi");
    i_sync_req_pin = 1'b0;
    idle(6);
    check({9'h000, o_sync_req}, 10'h001, "inv lo");
    rd_chk(12'h058, 8'h20, "pol rd");
    $display("test sync done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    idle(4);
    t_reset();
    t_swing();
    t_delay();
    t_ref();
    t_sync();
    tally_and_finish();
  end
endmodule // sysref_sync_ctrl_regs_bench
